// file: rtl/dcob_pkg.sv
// Package of offsets, fields, reset values and timing for the drive config bank
package dcob_pkg;
  // Register indices (byte address = 4 * index)
  localparam logic [15:0] DCOB_IDX_MULT = 16'h2057;
  localparam logic [15:0] DCOB_IDX_DIV = 16'h2058;
  localparam logic [15:0] DCOB_IDX_ENC_POS = 16'h205a;
  localparam logic [15:0] DCOB_IDX_MODE = 16'h205b;
  localparam logic [15:0] DCOB_IDX_DELAY = 16'h2084;
  localparam logic [15:0] DCOB_IDX_AVAIL = 16'h2101;
  localparam logic [15:0] DCOB_IDX_CTRL = 16'h2102;
  localparam logic [15:0] DCOB_IDX_DMASK = 16'h2103;
  localparam logic [15:0] DCOB_IDX_ENABLED = 16'h2104;
  localparam logic [15:0] DCOB_IDX_STATUS = 16'h2105;
  localparam logic [15:0] DCOB_IDX_PULSE_IN = 16'h2106;
  localparam logic [15:0] DCOB_IDX_SCALED = 16'h2107;
  // Reset values
  localparam logic [31:0] DCOB_RST_MULT = 32'h0000_0080;
  localparam logic [31:0] DCOB_RST_DIV = 32'h0000_0001;
  localparam logic [31:0] DCOB_RST_MODE = 32'h0000_0000;
  localparam logic [31:0] DCOB_RST_DELAY = 32'h0000_0000;
  localparam logic [31:0] DCOB_RST_AVAIL = 32'h0019_0021;
  localparam logic [31:0] DCOB_RST_DMASK = 32'h0000_0000;
  // Availability bit positions
  localparam int DCOB_BIT_USB = 0;
  localparam int DCOB_BIT_SERIAL_485 = 1;
  localparam int DCOB_BIT_SERIAL_232 = 2;
  localparam int DCOB_BIT_CAN = 3;
  localparam int DCOB_BIT_ETHERNET = 4;
  localparam int DCOB_BIT_REALTIME = 5;
  localparam int DCOB_BIT_SPI = 6;
  localparam int DCOB_BIT_MODBUS_SERIAL = 16;
  localparam int DCOB_BIT_MODBUS_NET = 17;
  localparam int DCOB_BIT_INDUSTRIAL_IP = 18;
  localparam int DCOB_IFACE_LSB = 0;
  localparam int DCOB_IFACE_MSB = 15;
  localparam int DCOB_PROTO_LSB = 16;
  localparam int DCOB_PROTO_MSB = 31;
  // Timing: one millisecond at 40 MHz
  localparam int DCOB_CLK_HZ = 40000000;
  localparam int DCOB_MS_PER_S = 1000;
  localparam int DCOB_CYC_PER_MS = DCOB_CLK_HZ / DCOB_MS_PER_S;
  // Readiness sequencer states, Gray coded
  typedef enum logic [1:0]
  {
    DCOB_ST_CAPTURE = 2'b00,
    DCOB_ST_WAIT = 2'b01,
    DCOB_ST_READY = 2'b11
  } dcob_state_t;
endpackage

// file: rtl/dcob_scaler.sv
// Pulse count scaler: multiply then divide, sequential signed divider
`timescale 1ns/1ps
module dcob_scaler
  import dcob_pkg::*;
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // Operands
  input wire logic i_start,
  input wire logic signed [31:0] i_count,
  input wire logic signed [31:0] i_mult,
  input wire logic signed [31:0] i_div,
  // Result
  output logic o_busy,
  output logic o_done,
  output logic signed [31:0] o_result
);
  logic [63:0] rem;
  logic [63:0] quo;
  logic [31:0] dvs;
  logic neg;
  logic [6:0] step;
  logic signed [31:0] signed_q;

  // Magnitude of a signed 64-bit value
  function automatic logic [63:0] dcob_abs64(input logic signed [63:0] v);
    dcob_abs64 = v[63] ? 64'(-v) : 64'(v);
  endfunction

  // Restoring division, one quotient bit per cycle; 65 cycles per result
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_result <= 32'sh0;
      rem <= 64'h0;
      quo <= 64'h0;
      dvs <= 32'h0;
      neg <= 1'b0;
      step <= 7'h0;
    end
    else
    begin
      o_done <= 1'b0;
      if (i_start && !o_busy)
      begin
        if (i_div == 32'sh0)
        begin
          // Zero divider: no division, product passed through
          o_result <= 32'(i_count * i_mult);
          o_done <= 1'b1;
        end
        else
        begin
          quo <= dcob_abs64(64'(i_count) * 64'(i_mult));
          dvs <= i_div[31] ? 32'(-i_div) : 32'(i_div);
          neg <= (i_count[31] ^ i_mult[31]) ^ i_div[31];
          rem <= 64'h0;
          step <= 7'd64;
          o_busy <= 1'b1;
        end
      end
      else if (o_busy)
      begin
        if (step == 7'd0)
        begin
          // Busy held through this cycle so no new start races the hand-over
          o_result <= signed_q;
          o_done <= 1'b1;
          o_busy <= 1'b0;
        end
        else
        begin
          if ({rem[62:0], quo[63]} >= {32'h0, dvs})
          begin
            rem <= {rem[62:0], quo[63]} - {32'h0, dvs};
            quo <= {quo[62:0], 1'b1};
          end
          else
          begin
            rem <= {rem[62:0], quo[63]};
            quo <= {quo[62:0], 1'b0};
          end
          step <= step - 7'd1;
        end
      end
    end
  end

  // Sign applied once the last quotient bit is in; quotient truncates toward zero
  assign signed_q = neg ? 32'(-quo[31:0]) : 32'(quo[31:0]);
endmodule

// file: rtl/dcob_bank.sv
// Drive configuration object bank with Avalon-MM slave
//
// Summary of operation
// - Step/direction: pulse count divided by signed divider, default one.
// - Step/direction: count multiplied by signed multiplier, default 0x80, before division.
// - Encoder position captured once after reset, read-only signed value.
// - Mode 0 selects step/direction, 1 selects cw/ccw; reset is 0.
// - Ready declared after the delay latched on the first cycle after reset, which is always the default zero.
// - Availability bits 0-15 physical interfaces, 16-31 protocol.
// - Bits 0..6: USB, 485, 232, CAN, Ethernet, realtime Ethernet, SPI.
// - Bits 16..18: serial Modbus, networked Modbus, industrial IP.
// - Availability map read-only, reads 0x00190021 after reset.
// - Writable control object; with the all-zero disable mask it switches nothing.
// - Control uses same bits; only disable-mask bits are switchable.
//
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/1ps
module dcob_bank
  import dcob_pkg::*;
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // Avalon-MM slave
  input wire logic [17:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic [1:0] o_avs_response,
  // Motion side
  input wire logic i_pulse_step,
  input wire logic i_pulse_dir,
  input wire logic i_pulse_cw,
  input wire logic i_pulse_ccw,
  input wire logic signed [31:0] i_encoder_position,
  // Drive state outputs
  output logic o_ready,
  output logic o_mode_cw_ccw,
  output logic signed [31:0] o_scaled_count,
  output logic o_scaled_valid,
  output logic [31:0] o_fieldbus_enabled
);
  logic signed [31:0] mult;
  logic signed [31:0] div;
  logic signed [31:0] enc_pos;
  logic [31:0] mode;
  logic [31:0] delay_ms;
  logic [31:0] ctrl;
  logic [31:0] pulse_count;
  dcob_state_t state;
  logic [31:0] ms_left;
  logic [15:0] ms_cyc;
  logic acc_done;
  logic [15:0] word_idx;
  logic wr_hit;
  logic [31:0] rd_val;
  logic rd_ok;

  // Byte-lane merge used by every writable register
  function automatic logic [31:0] dcob_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
    for (int i = 0; i < 4; i++)
      dcob_merge[i*8 +: 8] = be[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
  endfunction

  // Word index from byte address; one wait state per access, two when it directly follows an accepted one
  assign word_idx = i_avs_address[17:2];
  assign wr_hit = i_avs_write && o_avs_waitrequest == 1'b0 && !acc_done;

  // Waitrequest held high one cycle, or two straight after an accepted access, then dropped for the accepting edge
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      o_avs_waitrequest <= 1'b1;
      acc_done <= 1'b0;
    end
    else if ((i_avs_read || i_avs_write) && o_avs_waitrequest && !acc_done)
      o_avs_waitrequest <= 1'b0;
    else
    begin
      o_avs_waitrequest <= 1'b1;
      acc_done <= !o_avs_waitrequest;
    end
  end

  // Read mux: unmapped addresses answer zero with DECODEERROR
  always_comb
  begin
    rd_val = 32'h0;
    rd_ok = 1'b1;
    case (word_idx)
      DCOB_IDX_MULT: rd_val = mult;
      DCOB_IDX_DIV: rd_val = div;
      DCOB_IDX_ENC_POS: rd_val = enc_pos;
      DCOB_IDX_MODE: rd_val = mode;
      DCOB_IDX_DELAY: rd_val = delay_ms;
      DCOB_IDX_AVAIL: rd_val = DCOB_RST_AVAIL;
      DCOB_IDX_CTRL: rd_val = ctrl;
      DCOB_IDX_DMASK: rd_val = DCOB_RST_DMASK;
      DCOB_IDX_ENABLED: rd_val = o_fieldbus_enabled;
      DCOB_IDX_STATUS: rd_val = {30'h0, state == DCOB_ST_READY, o_mode_cw_ccw};
      DCOB_IDX_PULSE_IN: rd_val = pulse_count;
      DCOB_IDX_SCALED: rd_val = o_scaled_count;
      default: rd_ok = 1'b0;
    endcase
  end

  // Read data registered on the cycle waitrequest drops
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      o_avs_readdata <= 32'h0;
      o_avs_response <= 2'b00;
    end
    else if ((i_avs_read || i_avs_write) && o_avs_waitrequest && !acc_done)
    begin
      o_avs_readdata <= i_avs_read ? rd_val : 32'h0;
      o_avs_response <= rd_ok ? 2'b00 : 2'b11;
    end
  end

  // Writable configuration; read-only objects ignore writes
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      mult <= DCOB_RST_MULT;
      div <= DCOB_RST_DIV;
      mode <= DCOB_RST_MODE;
      delay_ms <= DCOB_RST_DELAY;
    end
    else if (wr_hit)
    begin
      case (word_idx)
        DCOB_IDX_MULT: mult <= dcob_merge(mult, i_avs_writedata, i_avs_byteenable);
        DCOB_IDX_DIV: div <= dcob_merge(div, i_avs_writedata, i_avs_byteenable);
        DCOB_IDX_MODE: mode <= dcob_merge(mode, i_avs_writedata, i_avs_byteenable);
        DCOB_IDX_DELAY: delay_ms <= dcob_merge(delay_ms, i_avs_writedata, i_avs_byteenable);
        default: ;
      endcase
    end
  end

  // Control object: only bits the disable mask marks may leave their preset
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
      ctrl <= DCOB_RST_AVAIL;
    else if (wr_hit && word_idx == DCOB_IDX_CTRL)
      ctrl <= (dcob_merge(ctrl, i_avs_writedata, i_avs_byteenable) & DCOB_RST_DMASK)
              | (ctrl & ~DCOB_RST_DMASK);
  end

  // Active buses: control limited to what the device has
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
      o_fieldbus_enabled <= DCOB_RST_AVAIL;
    else
      o_fieldbus_enabled <= ctrl & DCOB_RST_AVAIL;
  end

  // Mode decode straight from the selector's bit 0
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
      o_mode_cw_ccw <= 1'b0;
    else
      o_mode_cw_ccw <= mode[0];
  end

  // Power-up sequencer: capture position, then count milliseconds
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      state <= DCOB_ST_CAPTURE;
      enc_pos <= 32'sh0;
      ms_left <= 32'h0;
      ms_cyc <= 16'h0;
      o_ready <= 1'b0;
    end
    else
    begin
      case (state)
        DCOB_ST_CAPTURE:
        begin
          enc_pos <= i_encoder_position;
          ms_left <= delay_ms;
          ms_cyc <= 16'(DCOB_CYC_PER_MS - 1);
          state <= DCOB_ST_WAIT;
        end
        DCOB_ST_WAIT:
        begin
          if (ms_left == 32'h0)
          begin
            state <= DCOB_ST_READY;
            o_ready <= 1'b1;
          end
          else if (ms_cyc == 16'h0)
          begin
            ms_cyc <= 16'(DCOB_CYC_PER_MS - 1);
            ms_left <= ms_left - 32'h1;
          end
          else
            ms_cyc <= ms_cyc - 16'h1;
        end
        DCOB_ST_READY:
          o_ready <= 1'b1;
        default:
          state <= DCOB_ST_CAPTURE;
      endcase
    end
  end

  // Pulse input synchronisers, three stages each
  logic [2:0] s_step;
  logic [2:0] s_dir;
  logic [2:0] s_cw;
  logic [2:0] s_ccw;
  logic step_q;
  logic cw_q;
  logic ccw_q;
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      s_step <= 3'h0;
      s_dir <= 3'h0;
      s_cw <= 3'h0;
      s_ccw <= 3'h0;
      step_q <= 1'b0;
      cw_q <= 1'b0;
      ccw_q <= 1'b0;
    end
    else
    begin
      s_step <= {s_step[1:0], i_pulse_step};
      s_dir <= {s_dir[1:0], i_pulse_dir};
      s_cw <= {s_cw[1:0], i_pulse_cw};
      s_ccw <= {s_ccw[1:0], i_pulse_ccw};
      if (s_step[1] == s_step[2])
        step_q <= s_step[2];
      if (s_cw[1] == s_cw[2])
        cw_q <= s_cw[2];
      if (s_ccw[1] == s_ccw[2])
        ccw_q <= s_ccw[2];
    end
  end

  // Rising edges of the filtered levels drive the counter
  logic step_rise;
  logic cw_rise;
  logic ccw_rise;
  assign step_rise = s_step[1] == s_step[2] && s_step[2] && !step_q;
  assign cw_rise = s_cw[1] == s_cw[2] && s_cw[2] && !cw_q;
  assign ccw_rise = s_ccw[1] == s_ccw[2] && s_ccw[2] && !ccw_q;

  // Accumulated count, direction per selected interpretation
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
      pulse_count <= 32'h0;
    else if (!o_mode_cw_ccw && step_rise)
      pulse_count <= s_dir[2] ? pulse_count - 32'h1 : pulse_count + 32'h1;
    else if (o_mode_cw_ccw && (cw_rise ^ ccw_rise))
      pulse_count <= cw_rise ? pulse_count + 32'h1 : pulse_count - 32'h1;
  end

  // Rescale in step/direction mode whenever the scaler is free and the count moved
  logic sc_busy;
  logic sc_done;
  logic signed [31:0] sc_result;
  logic sc_start;
  logic [31:0] last_count;
  assign sc_start = !o_mode_cw_ccw && !sc_busy && (pulse_count != last_count);

  dcob_scaler u_scaler (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_start(sc_start),
    .i_count(pulse_count),
    .i_mult(mult),
    .i_div(div),
    .o_busy(sc_busy),
    .o_done(sc_done),
    .o_result(sc_result)
  );

  // Result capture; cw/ccw mode passes the raw count
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      last_count <= 32'h0;
      o_scaled_count <= 32'sh0;
      o_scaled_valid <= 1'b0;
    end
    else
    begin
      o_scaled_valid <= 1'b0;
      if (sc_start)
        last_count <= pulse_count;
      if (sc_done)
      begin
        o_scaled_count <= sc_result;
        o_scaled_valid <= 1'b1;
      end
      else if (o_mode_cw_ccw && pulse_count != last_count)
      begin
        // Raw count passes unscaled, flagged like a scaled result
        o_scaled_count <= pulse_count;
        o_scaled_valid <= 1'b1;
        last_count <= pulse_count;
      end
    end
  end

  // Assertions
  avail_const_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    i_avs_read && !o_avs_waitrequest && word_idx == DCOB_IDX_AVAIL
    && $past(i_avs_read) |-> o_avs_readdata == 32'h0019_0021)
    else $error("availability map not constant");
  ctrl_lock_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (ctrl & ~DCOB_RST_DMASK) == (DCOB_RST_AVAIL & ~DCOB_RST_DMASK))
    else $error("locked control bit changed");
  enc_hold_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    state == DCOB_ST_READY |=> $stable(enc_pos))
    else $error("encoder boot value changed");
  mode_map_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    ##1 o_mode_cw_ccw == $past(mode[0]))
    else $error("mode output mismatch");
  zero_delay_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    state == DCOB_ST_WAIT && ms_left == 32'h0 |=> o_ready)
    else $error("ready not raised");
  ready_gate_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    o_ready |-> state == DCOB_ST_READY)
    else $error("ready before wait ended");
  zero_div_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    sc_start && div == 32'sh0 |=> sc_done && sc_result == 32'($past(pulse_count) * $past(mult)))
    else $error("zero divider not bypassed");
  enabled_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    ##1 o_fieldbus_enabled == ($past(ctrl) & 32'h0019_0021))
    else $error("enabled map wrong");
  cov_write_c: cover property (@(posedge i_clk_sys) wr_hit && word_idx == DCOB_IDX_DIV);
  cov_ready_c: cover property (@(posedge i_clk_sys) $rose(o_ready));
  cov_scale_c: cover property (@(posedge i_clk_sys) sc_done && div != 32'sh0);
  cov_rotate_c: cover property (@(posedge i_clk_sys) o_mode_cw_ccw && o_scaled_valid);
endmodule

// file: dv/test_drive_config_object_bank.sv
// Register-level bench for the drive configuration object bank
`timescale 1ns/1ps
module test_drive_config_object_bank;
  import dcob_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_reset = 1'b1;
  logic [17:0] i_avs_address = 18'h0;
  logic i_avs_read = 1'b0;
  logic i_avs_write = 1'b0;
  logic [31:0] i_avs_writedata = 32'h0;
  logic [3:0] i_avs_byteenable = 4'hf;
  logic i_pulse_step = 1'b0;
  logic i_pulse_dir = 1'b1;
  logic i_pulse_cw = 1'b0;
  logic i_pulse_ccw = 1'b0;
  logic signed [31:0] i_encoder_position = 32'sh1234_5678;
  logic [31:0] o_avs_readdata;
  logic o_avs_waitrequest;
  logic [1:0] o_avs_response;
  logic o_ready;
  logic o_mode_cw_ccw;
  logic signed [31:0] o_scaled_count;
  logic o_scaled_valid;
  logic [31:0] o_fieldbus_enabled;
  int bad_count = 0;
  int total_checks = 0;
  logic [31:0] rd;
  logic [31:0] sc;
  logic [31:0] sgn;
  logic [1:0] rsp;
  logic [15:0] idx_tab [9];
  logic [31:0] rst_tab [9];

  dcob_bank dut_u (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .o_avs_response(o_avs_response),
    .i_pulse_step(i_pulse_step), .i_pulse_dir(i_pulse_dir), .i_pulse_cw(i_pulse_cw),
    .i_pulse_ccw(i_pulse_ccw), .i_encoder_position(i_encoder_position), .o_ready(o_ready),
    .o_mode_cw_ccw(o_mode_cw_ccw), .o_scaled_count(o_scaled_count),
    .o_scaled_valid(o_scaled_valid), .o_fieldbus_enabled(o_fieldbus_enabled));

  // 40 MHz system clock
  always #12.5 i_clk_sys = ~i_clk_sys;

  // Verdict and end of run
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
    begin
      $display("*** PASS ***");
    end
    else
    begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Compare tasks, one per result width
  task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      $display("Error %s expected %h seen %h", name, exp, got);
      bad_count++;
    end
  endtask

  task automatic chk_flag(input string name, input logic [1:0] exp, input logic [1:0] got);
    chk_word(name, {30'h0, exp}, {30'h0, got});
  endtask

  // A limit that runs out ends the run as a mismatch
  task automatic give_up(input string name);
    $display("Error %s expected event seen timeout", name);
    bad_count++;
    wrap_up();
  endtask

  // Waits for the grant; waitrequest and read data are taken at that same rising edge
  task automatic await_grant();
    int n;
    n = 0;
    do
    begin
      @(posedge i_clk_sys);
      n++;
      if (n > 50)
        give_up("waitrequest");
    end
    while (o_avs_waitrequest !== 1'b0);
    rd = o_avs_readdata;
    rsp = o_avs_response;
  endtask

  task automatic bus_rd(input logic [15:0] idx);
    @(posedge i_clk_sys);
    i_avs_address <= {idx, 2'b00};
    i_avs_read <= 1'b1;
    await_grant();
    i_avs_read <= 1'b0;
  endtask

  task automatic bus_wr(input logic [15:0] idx, input logic [31:0] d, input logic [3:0] be);
    @(posedge i_clk_sys);
    i_avs_address <= {idx, 2'b00};
    i_avs_writedata <= d;
    i_avs_byteenable <= be;
    i_avs_write <= 1'b1;
    await_grant();
    i_avs_write <= 1'b0;
  endtask

  // One pin rise, then the scaled result it produces
  task automatic pulse_scale(input bit use_cw);
    int n;
    @(posedge i_clk_sys);
    if (use_cw)
      i_pulse_cw <= 1'b1;
    else
      i_pulse_step <= 1'b1;
    n = 0;
    do
    begin
      @(negedge i_clk_sys);
      n++;
      if (n > 300)
        give_up("scaled_valid");
    end
    while (o_scaled_valid !== 1'b1);
    sc = o_scaled_count;
    @(posedge i_clk_sys);
    i_pulse_step <= 1'b0;
    i_pulse_cw <= 1'b0;
    repeat (4) @(posedge i_clk_sys);
  endtask

  initial
  begin
    idx_tab = '{DCOB_IDX_MULT, DCOB_IDX_DIV, DCOB_IDX_ENC_POS, DCOB_IDX_MODE, DCOB_IDX_DELAY,
      DCOB_IDX_AVAIL, DCOB_IDX_CTRL, DCOB_IDX_DMASK, DCOB_IDX_ENABLED};
    rst_tab = '{32'h0000_0080, 32'h0000_0001, 32'h1234_5678, 32'h0, 32'h0, 32'h0019_0021,
      32'h0019_0021, 32'h0, 32'h0019_0021};
    repeat (3) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    chk_flag("ready_in_reset", 2'b00, {1'b0, o_ready});
    // Zero delay: ready within a few cycles of release
    repeat (6) @(posedge i_clk_sys);
    chk_flag("ready", 2'b01, {1'b0, o_ready});
    // Encoder moves after capture; the captured value must not follow
    i_encoder_position <= 32'sh0bad_0001;
    for (int i = 0; i < 9; i++)
    begin
      bus_rd(idx_tab[i]);
      chk_word("reset_value", rst_tab[i], rd);
      chk_flag("response", 2'b00, rsp);
    end
    chk_flag("usb_bit", 2'b01, {1'b0, rd[DCOB_BIT_USB]});
    chk_flag("realtime_bit", 2'b01, {1'b0, rd[DCOB_BIT_REALTIME]});
    chk_flag("serial_modbus", 2'b01, {1'b0, rd[DCOB_BIT_MODBUS_SERIAL]});
    chk_flag("ip_bit", 2'b00, {1'b0, rd[DCOB_BIT_INDUSTRIAL_IP]});
    chk_word("enabled_pins", 32'h0019_0021, o_fieldbus_enabled);
    $display("test reset_values done");

    // Read-only objects refuse writes quietly
    bus_wr(DCOB_IDX_ENC_POS, 32'hffff_ffff, 4'hf);
    chk_flag("ro_wr_resp", 2'b00, rsp);
    bus_rd(DCOB_IDX_ENC_POS);
    chk_word("enc_pos", 32'h1234_5678, rd);
    bus_wr(DCOB_IDX_AVAIL, 32'h0, 4'hf);
    bus_rd(DCOB_IDX_AVAIL);
    chk_word("avail", 32'h0019_0021, rd);
    // Control with an all-zero mask switches nothing
    bus_wr(DCOB_IDX_CTRL, 32'h0, 4'hf);
    bus_rd(DCOB_IDX_ENABLED);
    chk_word("enabled", 32'h0019_0021, rd);
    chk_word("enabled_pins", 32'h0019_0021, o_fieldbus_enabled);
    bus_rd(16'h0000);
    chk_flag("unmapped_resp", 2'b11, rsp);
    chk_word("unmapped_data", 32'h0, rd);
    bus_wr(DCOB_IDX_DELAY, 32'haabb_ccdd, 4'b0101);
    bus_rd(DCOB_IDX_DELAY);
    chk_word("delay_lanes", 32'h00bb_00dd, rd);
    bus_wr(DCOB_IDX_DELAY, 32'h0, 4'hf);
    $display("test access_kinds done");

    // Scaling: 5/2 truncates, then a zero divider passes the product
    bus_wr(DCOB_IDX_MULT, 32'h5, 4'hf);
    bus_wr(DCOB_IDX_DIV, 32'h2, 4'hf);
    pulse_scale(1'b0);
    bus_rd(DCOB_IDX_PULSE_IN);
    // Direction pin held high counts down
    sgn = 32'hffff_ffff;
    chk_word("raw_count", sgn, rd);
    chk_word("scaled_1", 32'(2 * signed'(sgn)), sc);
    pulse_scale(1'b0);
    chk_word("scaled_2", 32'(5 * signed'(sgn)), sc);
    bus_wr(DCOB_IDX_DIV, 32'h0, 4'hf);
    pulse_scale(1'b0);
    chk_word("scaled_div0", 32'(15 * signed'(sgn)), sc);
    bus_rd(DCOB_IDX_SCALED);
    chk_word("scaled_reg", 32'(15 * signed'(sgn)), rd);
    $display("test scaling done");

    // Rotation-pulse mode bypasses the scaling ratio
    bus_wr(DCOB_IDX_MODE, 32'h1, 4'hf);
    bus_rd(DCOB_IDX_MODE);
    chk_word("mode", 32'h1, rd);
    chk_flag("mode_pin", 2'b01, {1'b0, o_mode_cw_ccw});
    pulse_scale(1'b1);
    bus_rd(DCOB_IDX_PULSE_IN);
    chk_word("cw_raw", 32'hffff_fffe, rd);
    chk_word("cw_scaled", 32'hffff_fffe, sc);
    bus_wr(DCOB_IDX_MODE, 32'h0, 4'hf);
    bus_rd(DCOB_IDX_STATUS);
    chk_flag("status", 2'b10, rd[1:0]);
    $display("test pulse_mode done");
    wrap_up();
  end
endmodule
